/* File: hw/dma_arb_pkg.sv */
// Package: register indices, field positions, reset values and carrier types
// Assumes APB with 32-bit data; byte address is four times a register index
package dma_arb_pkg;
  // ==========================================================
  // Channel geometry
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int PADDR_W = 12;
  // ==========================================================
  // Register indices
  localparam logic [9:0] IDX_IRQ_PRIO_C = 10'h0ba;
  localparam logic [9:0] IDX_IRQ_PRIO_A = 10'h0bb;
  localparam logic [9:0] IDX_IRQ_PRIO_B = 10'h0bc;
  localparam logic [9:0] IDX_IRQ_PRIO_D = 10'h0c2;
  localparam logic [9:0] IDX_IRQ_PRIO_E = 10'h0c6;
  localparam logic [9:0] IDX_STATUS_FIRST = 10'h0a0;
  localparam logic [9:0] IDX_STATUS_SECOND = 10'h0a1;
  localparam logic [9:0] IDX_LAST_RAM_OFFSET = 10'h0a2;
  localparam logic [9:0] IDX_INT_CONTROL_FIRST = 10'h0a3;
  localparam logic [9:0] IDX_CHANNEL_CONFIG = 10'h0a4;
  localparam logic [9:0] IDX_FORCE = 10'h0a5;
  localparam logic [9:0] IDX_OVERRUN = 10'h0a6;
  // ==========================================================
  // Field positions and reset values
  localparam int RAM_COL_LSB = 0;
  localparam int PER_COL_LSB = 8;
  localparam int LAST_CH_LSB = 0;
  localparam int PINGPONG_LSB = 8;
  localparam int DIR_LSB = 0;
  localparam int IRQ_EN_LSB = 8;
  localparam int CTRL_ERR_BIT = 5;
  localparam logic [15:0] IRQ_PRIO_RST = 16'h4444;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // ==========================================================
  // Carrier for one write port
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_s;
  typedef enum logic [0:0] {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } arb_state_e;
endpackage

/* File: hw/dma_arbitration_collision_unit.sv */
// Shared arbitration, request latching, write collision and debug logic of an
// eight-channel DMA controller, with an APB register slave.
// Assumes request, completion and write inputs come from logic on clk.
// What this block does
// - Fixed priority: channel 0 highest, channel 7 lowest.
// - Every incoming request to an unblocked channel outside sleep is held in a per-channel latch.
// - Grant at once when nothing runs and nothing else waits.
// - No other channel is granted until the current transfer completes.
// - Among several outstanding requests the highest priority wins, others wait.
// - Requests arriving mid-transfer join arbitration for the next grant.
// - A waiting request stays latched until higher channels are serviced.
// - A duplicate request to a latched channel is discarded, original kept.
// - A latch clears only when its channel's transfer completes.
// - Overrun is detected only for peripheral-to-RAM channels.
// - On same-address simultaneous writes the CPU write wins and a trap rises.
// - A read racing a write gets old data and raises nothing.
// - Same RAM address writes set the channel's RAM collision flag.
// - Same peripheral address writes set the channel's peripheral collision flag unless RAM also collides.
// - All collision flags are ORed into one fault trap.
// - Clearing the error status bit clears every collision flag.
// - A channel with a collision flag set ignores new requests.
// - A real collision sets one flag; both flags mean manual trigger error.
// - Record last channel, its RAM offset and ping-pong buffer used.
// - Arbitration, request latching, completion and DMA writes stop during sleep; APB and CPU writes go on.
// - In idle, transfers go on and block completion raises irq and wakes CPU.
// - A force onto a waiting peripheral request is dropped and sets both flags.
`timescale 1ns/100ps
module dma_arbitration_collision_unit
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dma_arb_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dma_arb_pkg::NUM_CH-1:0] periphReq,
  input wire logic xferDone,
  input wire logic blockDone,
  input wire logic [dma_arb_pkg::ADDR_W-1:0] xferRamOffset,
  input wire logic xferBuffer,
  input wire logic sleepMode,
  input wire logic idleMode,
  input wire dma_arb_pkg::wr_s cpuRamWr,
  input wire dma_arb_pkg::wr_s dmaRamWr,
  input wire dma_arb_pkg::wr_s cpuPerWr,
  input wire dma_arb_pkg::wr_s dmaPerWr,
  output dma_arb_pkg::wr_s ramWr,
  output dma_arb_pkg::wr_s perWr,
  output logic grantValid,
  output logic [dma_arb_pkg::CH_W-1:0] grantChannel,
  output logic faultTrap,
  output logic [dma_arb_pkg::NUM_CH-1:0] channelIrq,
  output logic cpuWake
);
  localparam int N = dma_arb_pkg::NUM_CH;

  // ==========================================================
  // State
  dma_arb_pkg::arb_state_e state;
  logic [N-1:0] latched;
  logic [N-1:0] ramColFlag;
  logic [N-1:0] perColFlag;
  logic [N-1:0] overrunFlag;
  logic [N-1:0] dirPerToRam;
  logic [N-1:0] irqEnable;
  logic [N-1:0] pingpong;
  logic [3:0] lastChannel;
  logic [15:0] lastRamOffset;
  logic errStatus;
  logic [15:0] prioA;
  logic [15:0] prioB;
  logic [15:0] prioC;
  logic [15:0] prioD;
  logic [15:0] prioE;

  // ==========================================================
  // APB decode
  wire [9:0] regIdx = paddr[11:2];
  wire apbAccess = psel & penable & ~pready;
  wire apbDone = psel & penable & pready;
  wire apbWrite = apbDone & pwrite & ~pslverr;
  wire selPrioA = regIdx == dma_arb_pkg::IDX_IRQ_PRIO_A;
  wire selPrioB = regIdx == dma_arb_pkg::IDX_IRQ_PRIO_B;
  wire selPrioC = regIdx == dma_arb_pkg::IDX_IRQ_PRIO_C;
  wire selPrioD = regIdx == dma_arb_pkg::IDX_IRQ_PRIO_D;
  wire selPrioE = regIdx == dma_arb_pkg::IDX_IRQ_PRIO_E;
  wire selStat1 = regIdx == dma_arb_pkg::IDX_STATUS_FIRST;
  wire selStat2 = regIdx == dma_arb_pkg::IDX_STATUS_SECOND;
  wire selOffset = regIdx == dma_arb_pkg::IDX_LAST_RAM_OFFSET;
  wire selIntCtl = regIdx == dma_arb_pkg::IDX_INT_CONTROL_FIRST;
  wire selConfig = regIdx == dma_arb_pkg::IDX_CHANNEL_CONFIG;
  wire selForce = regIdx == dma_arb_pkg::IDX_FORCE;
  wire selOverrun = regIdx == dma_arb_pkg::IDX_OVERRUN;
  wire anySel = selPrioA | selPrioB | selPrioC | selPrioD | selPrioE | selStat1 | selStat2 |
    selOffset | selIntCtl | selConfig | selForce | selOverrun;
  wire [N-1:0] forceReq = (apbWrite & selForce & ~sleepMode) ? pwdata[N-1:0] : '0;
  wire errClear = apbWrite & selIntCtl & ~pwdata[dma_arb_pkg::CTRL_ERR_BIT];
  wire [N-1:0] overrunClear = (apbWrite & selOverrun) ? pwdata[N-1:0] : '0;

  wire [15:0] stat1Word = {perColFlag, ramColFlag};
  wire [15:0] stat2Word = {pingpong, 4'h0, lastChannel};
  wire [15:0] intCtlWord = 16'(errStatus) << dma_arb_pkg::CTRL_ERR_BIT;
  wire [15:0] configWord = {irqEnable, dirPerToRam};
  wire [15:0] readWord =
    selPrioA ? prioA :
    selPrioB ? prioB :
    selPrioC ? prioC :
    selPrioD ? prioD :
    selPrioE ? prioE :
    selStat1 ? stat1Word :
    selStat2 ? stat2Word :
    selOffset ? lastRamOffset :
    selIntCtl ? intCtlWord :
    selConfig ? configWord :
    selOverrun ? {8'h00, overrunFlag} :
    dma_arb_pkg::ZERO16;

  // One wait state: answer registered in the access phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apbAccess;
      pslverr <= apbAccess & ~anySel;
      if (apbAccess)
        prdata <= {16'h0000, readWord};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prioA <= dma_arb_pkg::IRQ_PRIO_RST;
      prioB <= dma_arb_pkg::IRQ_PRIO_RST;
      prioC <= dma_arb_pkg::IRQ_PRIO_RST;
      prioD <= dma_arb_pkg::IRQ_PRIO_RST;
      prioE <= dma_arb_pkg::IRQ_PRIO_RST;
      dirPerToRam <= '0;
      irqEnable <= '0;
    end
    else if (apbWrite)
    begin
      if (selPrioA) prioA <= pwdata[15:0];
      if (selPrioB) prioB <= pwdata[15:0];
      if (selPrioC) prioC <= pwdata[15:0];
      if (selPrioD) prioD <= pwdata[15:0];
      if (selPrioE) prioE <= pwdata[15:0];
      if (selConfig) dirPerToRam <= pwdata[7:0];
      if (selConfig) irqEnable <= pwdata[15:8];
    end
  end

  // ==========================================================
  // Arbitration
  // Lowest index wins
  function automatic logic [dma_arb_pkg::CH_W-1:0] pick(input logic [N-1:0] req);
    logic [dma_arb_pkg::CH_W-1:0] ch;
    ch = '0;
    for (int i = N - 1; i >= 0; i--)
      if (req[i]) ch = dma_arb_pkg::CH_W'(i);
    return ch;
  endfunction

  wire busy = state == dma_arb_pkg::ARB_BUSY;
  wire completing = busy & xferDone & ~sleepMode;
  // Grant only from idle and never during sleep
  wire startGrant = ~busy & (|latched) & ~sleepMode;
  wire [dma_arb_pkg::CH_W-1:0] winner = pick(latched);
  wire [N-1:0] blocked = ramColFlag | perColFlag;
  wire [N-1:0] doneOneHot = completing ? (N'(1) << grantChannel) : '0;
  wire ramHit = cpuRamWr.en & dmaRamWr.en & (cpuRamWr.addr == dmaRamWr.addr) & busy;
  wire perHit = cpuPerWr.en & dmaPerWr.en & (cpuPerWr.addr == dmaPerWr.addr) & busy;
  // One flag per real collision, RAM preferred
  wire [N-1:0] ramColSet = ramHit ? (N'(1) << grantChannel) : '0;
  wire [N-1:0] perColSet = (perHit & ~ramHit) ? (N'(1) << grantChannel) : '0;

  // Hold grant until completion, then rearbitrate
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= dma_arb_pkg::ARB_IDLE;
      grantValid <= 1'b0;
      grantChannel <= '0;
    end
    else
    begin
      unique case (state)
        dma_arb_pkg::ARB_IDLE:
        begin
          if (startGrant)
          begin
            state <= dma_arb_pkg::ARB_BUSY;
            grantValid <= 1'b1;
            grantChannel <= winner;
          end
        end
        dma_arb_pkg::ARB_BUSY:
        begin
          if (completing)
          begin
            state <= dma_arb_pkg::ARB_IDLE;
            grantValid <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Per-channel request latch and flags
  logic [N-1:0] forceError;
  generate
    for (genvar i = 0; i < N; i++)
    begin : g_ch
      wire live = ~blocked[i] & ~sleepMode;
      // Force onto a waiting request is an error
      wire forceErr = forceReq[i] & latched[i] & ~doneOneHot[i];
      wire accept = live & (periphReq[i] | (forceReq[i] & ~forceErr));
      // Duplicate only counted when peripheral to RAM
      wire dup = live & periphReq[i] & latched[i] & ~doneOneHot[i] & dirPerToRam[i];
      assign forceError[i] = forceErr;
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          latched[i] <= 1'b0;
          ramColFlag[i] <= 1'b0;
          perColFlag[i] <= 1'b0;
          overrunFlag[i] <= 1'b0;
        end
        else
        begin
          // Hold until own completion; blocked when faulted
          latched[i] <= (latched[i] & ~doneOneHot[i]) | accept;
          ramColFlag[i] <= (ramColFlag[i] & ~errClear) | ramColSet[i] | forceErr;
          perColFlag[i] <= (perColFlag[i] & ~errClear) | perColSet[i] | forceErr;
          overrunFlag[i] <= (overrunFlag[i] & ~overrunClear[i]) | dup;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Error status, trap, debug and idle wake
  wire anyColSet = (|ramColSet) | (|perColSet) | (|forceError);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      errStatus <= 1'b0;
      faultTrap <= 1'b0;
      lastChannel <= 4'h0;
      lastRamOffset <= 16'h0000;
      pingpong <= '0;
      channelIrq <= '0;
      cpuWake <= 1'b0;
    end
    else
    begin
      // Clear of error status, set wins
      errStatus <= (errStatus & ~errClear) | anyColSet;
      faultTrap <= (|(ramColFlag | ramColSet | perColFlag | perColSet | forceError)) & ~errClear |
        anyColSet;
      if (completing)
      begin
        lastChannel <= {1'b0, grantChannel};
        lastRamOffset <= xferRamOffset;
        pingpong[grantChannel] <= xferBuffer;
      end
      // Block completion irq and idle wake
      channelIrq <= (blockDone ? doneOneHot : '0) & irqEnable;
      cpuWake <= (|((blockDone ? doneOneHot : '0) & irqEnable)) & idleMode;
    end
  end

  // ==========================================================
  // Write ports: CPU prevails, reads are untouched
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ramWr <= '0;
      perWr <= '0;
    end
    else
    begin
      // CPU write takes the port; dma passes when cpu is quiet
      ramWr <= cpuRamWr.en ? cpuRamWr : ((dmaRamWr.en & busy & ~sleepMode) ? dmaRamWr : '0);
      perWr <= cpuPerWr.en ? cpuPerWr : ((dmaPerWr.en & busy & ~sleepMode) ? dmaPerWr : '0);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_idleWithReq;
    !busy && (|latched) && !sleepMode;
  endsequence
  sequence s_granted;
    grantValid && grantChannel == $past(winner);
  endsequence

  property p_grantPriority;
    s_idleWithReq |=> s_granted;
  endproperty
  a_grantPriority: assert property (p_grantPriority) else $error("grant not to top channel");

  property p_grantHeld;
    (busy && !completing) |=> grantValid && $stable(grantChannel);
  endproperty
  a_grantHeld: assert property (p_grantHeld) else $error("grant changed mid transfer");

  property p_latchHeld;
    (latched != 0 && !busy) |-> ##0 1'b1 ##1 (latched[$past(winner)]);
  endproperty
  a_latchHeld: assert property (p_latchHeld) else $error("winner latch lost before completion");

  property p_clearOnDone;
    (completing && !periphReq[grantChannel] && !forceReq[grantChannel]) |=> !latched[$past(grantChannel)];
  endproperty
  a_clearOnDone: assert property (p_clearOnDone) else $error("latch not cleared on completion");

  property p_capture;
    (periphReq[0] && !blocked[0] && !sleepMode) |=> latched[0];
  endproperty
  a_capture: assert property (p_capture) else $error("request not latched");

  property p_cpuWins;
    cpuRamWr.en |=> ramWr == $past(cpuRamWr);
  endproperty
  a_cpuWins: assert property (p_cpuWins) else $error("cpu write lost");

  property p_trap;
    (ramHit || perHit) |=> faultTrap && errStatus;
  endproperty
  a_trap: assert property (p_trap) else $error("collision without trap");

  property p_clearFlags;
    (errClear && !anyColSet) |=> ramColFlag == 0 && perColFlag == 0 && !faultTrap;
  endproperty
  a_clearFlags: assert property (p_clearFlags) else $error("flags not cleared");

  property p_blocked;
    (blocked[3] && !latched[3]) |=> !latched[3];
  endproperty
  a_blocked: assert property (p_blocked) else $error("faulted channel took request");

  property p_oneFlag;
    (ramHit && perHit && forceError == 0 && !errClear) |=> ($past(perColFlag) == perColFlag);
  endproperty
  a_oneFlag: assert property (p_oneFlag) else $error("both flags set by collision");

  property p_sleep;
    sleepMode |=> !$rose(grantValid);
  endproperty
  a_sleep: assert property (p_sleep) else $error("grant during sleep");

  property p_wake;
    (completing && blockDone && irqEnable[grantChannel] && idleMode) |=> cpuWake && $countones(channelIrq) == 1;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on block end");

  property p_forceErr;
    (forceError != 0) |=> ((ramColFlag & perColFlag & $past(forceError)) == $past(forceError));
  endproperty
  a_forceErr: assert property (p_forceErr) else $error("force error flags missing");
endmodule

/* File: dv/dma_far_model.sv */
// Channel datapath model: finishes each granted transfer
// Assumes the unit's grant outputs; raises xferDone DLY+1 cycles after grantValid rises
`timescale 1ns/100ps
module dma_far_model
#(
  parameter int DLY = 6
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic grantValid,
  input wire logic [2:0] grantChannel,
  input wire logic endBlock,
  output logic xferDone,
  output logic blockDone,
  output logic [15:0] xferRamOffset,
  output logic xferBuffer
);
  int cnt;
  logic served;
  // Offset and buffer only meaningful with xferDone
  assign xferRamOffset = xferDone ? {13'h0010, grantChannel} : {13'h1fef, ~grantChannel};
  assign xferBuffer = xferDone ? grantChannel[0] : ~grantChannel[0];
  assign blockDone = xferDone & endBlock;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 0;
      served <= 1'b0;
      xferDone <= 1'b0;
    end
    else
    begin
      xferDone <= 1'b0;
      if (!grantValid)
      begin
        cnt <= 0;
        served <= 1'b0;
      end
      else if (!served && cnt == DLY)
      begin
        xferDone <= 1'b1;
        served <= 1'b1;
      end
      else if (!served)
        cnt <= cnt + 1;
    end
  end
endmodule

/* File: dv/tb.sv */
// Testbench: APB register tasks plus request and write stimulus
// Assumes dma_far_model completes every grant
`timescale 1ns/100ps
module tb;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, rerr, sleepMode = 0, idleMode = 0, endBlock = 0;
  logic [7:0] periphReq = 0, channelIrq;
  logic xferDone, blockDone, xferBuffer, grantValid, faultTrap, cpuWake, gvD = 0;
  logic [15:0] xferRamOffset, ramD = 0, perD = 0;
  logic [2:0] grantChannel;
  logic [31:0] gLog = 0;
  dma_arb_pkg::wr_s cpuRamWr = '0, dmaRamWr = '0, cpuPerWr = '0, dmaPerWr = '0, ramWr, perWr;
  int fail_count = 0, n_compared = 0, gCnt = 0, irqN = 0, wakeN = 0, c, k;
  always #5 clk = ~clk;
  dma_arbitration_collision_unit uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periphReq(periphReq), .xferDone(xferDone), .blockDone(blockDone),
    .xferRamOffset(xferRamOffset), .xferBuffer(xferBuffer), .sleepMode(sleepMode),
    .idleMode(idleMode), .cpuRamWr(cpuRamWr), .dmaRamWr(dmaRamWr), .cpuPerWr(cpuPerWr),
    .dmaPerWr(dmaPerWr), .ramWr(ramWr), .perWr(perWr), .grantValid(grantValid),
    .grantChannel(grantChannel), .faultTrap(faultTrap), .channelIrq(channelIrq), .cpuWake(cpuWake));
  dma_far_model far (.clk(clk), .arst_n(arst_n), .grantValid(grantValid), .grantChannel(grantChannel),
    .endBlock(endBlock), .xferDone(xferDone), .blockDone(blockDone),
    .xferRamOffset(xferRamOffset), .xferBuffer(xferBuffer));
  // ==========================================================
  // Monitor: grant log, winning writes, pulses
  always @(posedge clk)
  begin
    gvD <= grantValid;
    if (grantValid && !gvD)
    begin
      gLog <= {gLog[27:0], 1'b1, grantChannel};
      gCnt <= gCnt + 1;
    end
    if (ramWr.en) ramD <= ramWr.data;
    if (perWr.en) perD <= perWr.data;
    if (channelIrq == 8'h01) irqN <= irqN + 1;
    if (cpuWake) wakeN <= wakeN + 1;
  end
  // ==========================================================
  // Tasks
  task stop_test;
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20)
    begin
      chk("pready", 1, 0);
      stop_test();
    end
  endtask
  task rchk(input string nm, input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(nm, e, rdat);
  endtask
  task req(input logic [7:0] m);
    periphReq <= m;
    @(posedge clk);
    periphReq <= 8'h00;
  endtask
  task waitCnt(input int n, input logic idle);
    int t;
    t = 0;
    while ((gCnt < n || (idle && grantValid !== 1'b0)) && t < 400)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 400)
    begin
      chk("grant wait", 1, 0);
      stop_test();
    end
  endtask
  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk("prio_a", dma_arb_pkg::IDX_IRQ_PRIO_A, 32'h4444);
    rchk("prio_b", dma_arb_pkg::IDX_IRQ_PRIO_B, 32'h4444);
    rchk("prio_c", dma_arb_pkg::IDX_IRQ_PRIO_C, 32'h4444);
    rchk("prio_d", dma_arb_pkg::IDX_IRQ_PRIO_D, 32'h4444);
    rchk("prio_e", dma_arb_pkg::IDX_IRQ_PRIO_E, 32'h4444);
    apb(1'b1, dma_arb_pkg::IDX_IRQ_PRIO_D, 32'h1234);
    rchk("prio_d rw", dma_arb_pkg::IDX_IRQ_PRIO_D, 32'h1234);
    rchk("unmapped", 10'h3ff, 32'h0);
    chk("pslverr", 1, rerr);
    req(8'ha4);
    waitCnt(3, 1);
    chk("order", 32'h0adf, gLog[15:0]);
    req(8'h28);
    waitCnt(4, 0);
    req(8'h22);
    waitCnt(6, 1);
    repeat (12) @(posedge clk);
    chk("order", 32'hfb9d, gLog[15:0]);
    chk("dup dropped", 6, gCnt);
    // Buffer bits of channels 1, 3, 5, 7 set; channel 5 ran last
    rchk("last ch", dma_arb_pkg::IDX_STATUS_SECOND, 32'haa05);
    rchk("last ofs", dma_arb_pkg::IDX_LAST_RAM_OFFSET, 32'h0085);
    apb(1'b1, dma_arb_pkg::IDX_CHANNEL_CONFIG, 32'h0040);
    req(8'hc1);
    waitCnt(7, 0);
    req(8'hc0);
    waitCnt(9, 1);
    rchk("overrun", dma_arb_pkg::IDX_OVERRUN, 32'h0040);
    apb(1'b1, dma_arb_pkg::IDX_OVERRUN, 32'h0040);
    rchk("overrun w1c", dma_arb_pkg::IDX_OVERRUN, 32'h0);
    // Pass 0 collides on both ports at once, pass 1 on the peripheral only
    for (k = 0; k < 2; k++)
    begin
      c = gCnt;
      req(k ? 8'h10 : 8'h08);
      waitCnt(c + 1, 0);
      if (k) {cpuPerWr, dmaPerWr} <= {1'b1, 32'h0040aaaa, 1'b1, 32'h00405555};
      else {cpuRamWr, dmaRamWr, cpuPerWr, dmaPerWr} <= {2{1'b1, 32'h0040aaaa, 1'b1, 32'h00405555}};
      @(posedge clk);
      {cpuRamWr, dmaRamWr, cpuPerWr, dmaPerWr} <= '0;
      waitCnt(c + 1, 1);
      chk("cpu wins", 32'haaaa, k ? perD : ramD);
      rchk("col flag", dma_arb_pkg::IDX_STATUS_FIRST, k ? 32'h1000 : 32'h0008);
      chk("trap", 1, faultTrap);
      req(k ? 8'h10 : 8'h08);
      repeat (12) @(posedge clk);
      chk("blocked", c + 1, gCnt);
      apb(1'b1, dma_arb_pkg::IDX_INT_CONTROL_FIRST, 32'h0);
      rchk("flags clr", dma_arb_pkg::IDX_STATUS_FIRST, 32'h0);
      chk("trap clr", 0, faultTrap);
    end
    c = gCnt;
    req(8'h44);
    waitCnt(c + 1, 0);
    apb(1'b1, dma_arb_pkg::IDX_FORCE, 32'h0040);
    waitCnt(c + 2, 1);
    repeat (12) @(posedge clk);
    chk("force drop", c + 2, gCnt);
    rchk("both flags", dma_arb_pkg::IDX_STATUS_FIRST, 32'h4040);
    apb(1'b1, dma_arb_pkg::IDX_INT_CONTROL_FIRST, 32'h0);
    // Nothing in flight when sleep begins
    sleepMode <= 1'b1;
    req(8'h01);
    sleepMode <= 1'b0;
    repeat (12) @(posedge clk);
    chk("sleep", c + 2, gCnt);
    apb(1'b1, dma_arb_pkg::IDX_CHANNEL_CONFIG, 32'h0100);
    idleMode <= 1'b1;
    endBlock <= 1'b1;
    req(8'h03);
    waitCnt(c + 4, 1);
    repeat (3) @(posedge clk);
    chk("irq", 1, irqN);
    chk("wake", 1, wakeN);
    stop_test();
  end
endmodule
